// ===== spsq_sequencer.sv
/*
  smoke pulse alarm sequencer: schedules emitter pulses, takes the threshold
  comparator result at the end of each pulse, counts consecutive hits and
  latches the alarm that drives the built-in and remote indicators.
  assumes the comparator output is asynchronous and stays settled for the
  whole emitter pulse; rst_i is the power-on or external reset.
*/
`timescale 1ns/1ns
`default_nettype none
module spsq_sequencer
  import spsq_pkg::*;
#(
  parameter int unsigned IDLE_CYC = IDLE_PERIOD_CYC,
  parameter int unsigned CONFIRM_CYC = CONFIRM_PERIOD_CYC
)
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // threshold comparator, asynchronous
  input wire logic above_thr_i,
  // emitter drive
  output logic emit_o,
  // per-pulse result
  output logic result_valid_o,
  output logic result_above_o,
  output logic [HIT_W-1:0] hit_count_o,
  // alarm indicators
  output logic alarm_led_o,
  output logic remote_led_en_o
);
  // timer load values: pulse width and the off time that completes a period
  localparam logic [TMR_W-1:0] EMIT_LOAD = TMR_W'(EMIT_CYC - 1);
  localparam logic [TMR_W-1:0] IDLE_LOAD = TMR_W'(IDLE_CYC - EMIT_CYC - 1);
  localparam logic [TMR_W-1:0] CONFIRM_LOAD = TMR_W'(CONFIRM_CYC - EMIT_CYC - 1);

  logic above_meta_reg;
  logic above_sync_reg;
  spsq_state_t state_reg;
  spsq_state_t state_next;
  logic emit_reg;
  logic emit_next;
  logic short_reg;
  logic short_next;
  logic [HIT_W-1:0] hit_reg;
  logic [HIT_W-1:0] hit_next;
  logic alarm_reg;
  logic alarm_next;
  logic valid_reg;
  logic valid_next;
  logic above_reg;
  logic above_next;
  logic tmr_load;
  logic [TMR_W-1:0] tmr_val;
  logic tmr_expire;

  // two-stage synchroniser for the comparator pin
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      above_meta_reg <= 1'b0;
      above_sync_reg <= 1'b0;
    end else begin
      above_meta_reg <= above_thr_i;
      above_sync_reg <= above_meta_reg;
    end
  end

  // shared interval and pulse-width timer
  spsq_timer u_timer (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .load_i(tmr_load),
    .load_val_i(tmr_val),
    .expire_o(tmr_expire)
  );

  // pulse scheduling, result capture, hit counting and alarm latch
  always_comb begin
    state_next = state_reg;
    emit_next = emit_reg;
    short_next = short_reg;
    hit_next = hit_reg;
    alarm_next = alarm_reg;
    valid_next = 1'b0;
    above_next = above_reg;
    tmr_load = 1'b0;
    tmr_val = IDLE_LOAD;
    case (state_reg)
      ST_START: begin
        tmr_load = 1'b1;
        state_next = ST_WAIT;
      end
      ST_WAIT: begin
        if (tmr_expire) begin
          tmr_load = 1'b1;
          tmr_val = EMIT_LOAD;
          emit_next = 1'b1;
          state_next = ST_FIRE;
        end
      end
      ST_FIRE: begin
        if (tmr_expire) begin
          emit_next = 1'b0;
          valid_next = 1'b1;
          above_next = above_sync_reg;
          tmr_load = 1'b1;
          state_next = ST_WAIT;
          if (above_sync_reg) begin
            short_next = 1'b1;
            tmr_val = CONFIRM_LOAD;
            if (hit_reg != HIT_ALARM) begin
              hit_next = hit_reg + HIT_ONE;
            end
            if (hit_reg >= HIT_ALARM - HIT_ONE) begin
              alarm_next = 1'b1;
            end
          end else begin
            short_next = 1'b0;
            tmr_val = IDLE_LOAD;
            if (!alarm_reg) begin
              hit_next = HIT_ZERO;
            end
          end
        end
      end
      default: begin
        state_next = ST_START;
      end
    endcase
  end

  // register the sequencer state
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_reg <= ST_START;
      emit_reg <= 1'b0;
      short_reg <= 1'b0;
      hit_reg <= HIT_ZERO;
      alarm_reg <= 1'b0;
      valid_reg <= 1'b0;
      above_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      emit_reg <= emit_next;
      short_reg <= short_next;
      hit_reg <= hit_next;
      alarm_reg <= alarm_next;
      valid_reg <= valid_next;
      above_reg <= above_next;
    end
  end

  // outputs straight from flops
  assign emit_o = emit_reg;
  assign result_valid_o = valid_reg;
  assign result_above_o = above_reg;
  assign hit_count_o = hit_reg;
  assign alarm_led_o = alarm_reg;
  assign remote_led_en_o = alarm_reg;

  // helper: cycles between emitter rises, on-time, and rise history
  // gap_reg restarts on the rise edge itself, so the spacing is its value one cycle back
  logic [31:0] gap_reg;
  logic [31:0] width_reg;
  logic seen_rise_reg;
  logic short_at_rise_reg;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      gap_reg <= '0;
      width_reg <= '0;
      seen_rise_reg <= 1'b0;
      short_at_rise_reg <= 1'b0;
    end else begin
      gap_reg <= (emit_next && !emit_reg) ? 32'h1 : gap_reg + 32'h1;
      width_reg <= emit_reg ? width_reg + 32'h1 : 32'h0;
      if (emit_next && !emit_reg) begin
        seen_rise_reg <= 1'b1;
        short_at_rise_reg <= short_reg;
      end
    end
  end

  sequence s_hit;
    result_valid_o && result_above_o;
  endsequence
  sequence s_miss;
    result_valid_o && !result_above_o;
  endsequence
  sequence s_rise_after_first;
    $rose(emit_o) && $past(seen_rise_reg);
  endsequence

  AST_IDLE_PERIOD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_rise_after_first ##0 !short_at_rise_reg |-> $past(gap_reg) == IDLE_CYC)
    else $error("idle pulse spacing wrong");
  AST_PULSE_WIDTH: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $fell(emit_o) |-> width_reg == EMIT_CYC)
    else $error("emitter on-time wrong");
  AST_RESULT_TAKEN: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $fell(emit_o) |-> result_valid_o && result_above_o == $past(above_sync_reg))
    else $error("result not taken from comparator at pulse end");
  AST_SHORTEN: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_hit |-> short_reg ##1 !emit_o [*8])
    else $error("hit did not select short interval");
  AST_CONFIRM_PERIOD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_rise_after_first ##0 short_at_rise_reg |-> $past(gap_reg) == CONFIRM_CYC)
    else $error("confirmation pulse spacing wrong");
  AST_THIRD_HIT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_hit ##0 $past(hit_reg) == HIT_ALARM - HIT_ONE |-> alarm_led_o)
    else $error("alarm not latched on third hit");
  AST_NO_EARLY_ALARM: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(alarm_led_o) |-> s_hit ##0 hit_count_o == HIT_ALARM)
    else $error("alarm latched without three hits");
  AST_MISS_CLEARS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_miss ##0 !alarm_led_o |-> hit_count_o == HIT_ZERO && !short_reg)
    else $error("miss did not clear count and interval");
  AST_INDICATORS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(alarm_led_o) |-> remote_led_en_o ##1 (alarm_led_o && remote_led_en_o))
    else $error("indicators not driven together");
  AST_ALARM_HOLDS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    alarm_led_o |=> alarm_led_o && hit_count_o == HIT_ALARM)
    else $error("latched alarm dropped without reset");
endmodule
`default_nettype wire

// ===== spsq_pkg.sv
/*
  constants for the smoke pulse alarm sequencer: clock rate, pulse periods,
  emitter pulse width, counter widths and the confirmation count.
  assumes a single 20 MHz system clock.
*/
package spsq_pkg;
  // system clock
  localparam int unsigned CLK_HZ = 20_000_000;
  // pulse periods in seconds, start of one emitter pulse to the next
  localparam int unsigned IDLE_PERIOD_S = 10;
  localparam int unsigned CONFIRM_PERIOD_S = 2;
  // emitter on-time in microseconds and in clock cycles
  localparam int unsigned EMIT_WIDTH_US = 100;
  localparam int unsigned EMIT_CYC = (EMIT_WIDTH_US * (CLK_HZ / 1_000_000) > 0) ?
                                     EMIT_WIDTH_US * (CLK_HZ / 1_000_000) : 1;
  // default period counts, kept as top-level parameters
  localparam int unsigned IDLE_PERIOD_CYC = IDLE_PERIOD_S * CLK_HZ;
  localparam int unsigned CONFIRM_PERIOD_CYC = CONFIRM_PERIOD_S * CLK_HZ;
  // interval timer width, holds the longest period
  localparam int TMR_W = 28;
  // consecutive above-threshold pulses that latch the alarm
  localparam int HIT_W = 2;
  localparam logic [HIT_W-1:0] HIT_ZERO = 2'h0;
  localparam logic [HIT_W-1:0] HIT_ONE = 2'h1;
  localparam logic [HIT_W-1:0] HIT_ALARM = 2'h3;
  // sequencer states
  typedef enum logic [1:0] {ST_START, ST_WAIT, ST_FIRE} spsq_state_t;
endpackage

// ===== spsq_timer.sv
/*
  one-shot down counter: a load of value n gives a one-cycle expiry pulse
  that is seen by the loading logic at the n+1-th edge after the load edge.
  assumes the same clock and synchronous reset as the sequencer.
*/
`timescale 1ns/1ns
`default_nettype none
module spsq_timer
  import spsq_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // load request
  input wire logic load_i,
  input wire logic [TMR_W-1:0] load_val_i,
  // expiry pulse
  output logic expire_o
);
  logic [TMR_W-1:0] cnt_reg;
  logic [TMR_W-1:0] cnt_next;
  logic expire_reg;
  logic expire_next;

  // count down to zero, flag the step from one to zero
  always_comb begin
    cnt_next = cnt_reg;
    expire_next = 1'b0;
    if (load_i) begin
      cnt_next = load_val_i;
      expire_next = (load_val_i == '0);
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
      expire_next = (cnt_reg == {{(TMR_W-1){1'b0}}, 1'b1});
    end
  end

  // register the counter and the pulse
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      expire_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      expire_reg <= expire_next;
    end
  end

  assign expire_o = expire_reg;
endmodule
`default_nettype wire

// ===== spsq_chamber_model.sv
/*
  far-side model of the smoke chamber and threshold comparator: it answers the
  sequencer's emitter pulse with the smoke level that the testbench commands.
  assumes the sequencer clock and an emitter drive that is high while lit.
*/
`timescale 1ns/1ns
`default_nettype none
module spsq_chamber_model (
  // clock
  input wire logic sys_clk_i,
  // emitter drive and commanded smoke level
  input wire logic emit_i,
  input wire logic smoke_i,
  // comparator output
  output logic above_thr_o
);
  initial above_thr_o = 1'b0;
  // settled only under a lit emitter; toggles otherwise so no idle level helps
  always @(posedge sys_clk_i) begin
    above_thr_o <= emit_i ? smoke_i : ~above_thr_o;
  end
endmodule
`default_nettype wire

// ===== tb_spsq_sequencer.sv
/*
  self-checking testbench for the smoke pulse alarm sequencer: pulse spacing,
  per-pulse results, hit counting, alarm latch and reset.
  assumes the chamber model on the comparator input and shortened periods.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_spsq_sequencer;
  import spsq_pkg::*;
  localparam int unsigned IDLE_T = 6000;
  localparam int unsigned CONF_T = 3000;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic smoke = 1'b0;
  logic above_thr, emit, res_valid, res_above, alarm_led, remote_en;
  logic [HIT_W-1:0] hits;
  logic emit_d = 1'b0;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  int last_rise = 0;
  int period = 0;

  // clock generator
  always #25 sys_clk_i = ~sys_clk_i;

  spsq_sequencer #(.IDLE_CYC(IDLE_T), .CONFIRM_CYC(CONF_T)) i_dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .above_thr_i(above_thr),
    .emit_o(emit), .result_valid_o(res_valid), .result_above_o(res_above),
    .hit_count_o(hits), .alarm_led_o(alarm_led), .remote_led_en_o(remote_en));

  spsq_chamber_model i_model (
    .sys_clk_i(sys_clk_i), .emit_i(emit), .smoke_i(smoke), .above_thr_o(above_thr));

  // cycle count and rise-to-rise spacing of the emitter
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    emit_d <= emit;
    if (emit && !emit_d) begin
      period <= cyc - last_rise;
      last_rise <= cyc;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // set smoke level, wait for the next result, check width, spacing, result
  task automatic pulse(input logic lvl, input int unsigned gap);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    smoke <= lvl;
    do begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end while (res_valid !== 1'b1 && n < 8000);
    chk(res_valid, 1'b1);
    chk(cyc - last_rise, EMIT_CYC);
    if (gap != 0) chk(period, gap);
    chk(res_above, lvl);
  endtask

  // clean air: idle spacing, no hits
  task automatic sc_idle();
    pulse(1'b0, 0);
    chk(hits, HIT_ZERO);
    pulse(1'b0, IDLE_T);
    chk(alarm_led, 1'b0);
  endtask

  // one hit, then a miss on the second pulse
  task automatic sc_hit_miss();
    pulse(1'b1, IDLE_T);
    chk(hits, HIT_ONE);
    pulse(1'b0, CONF_T);
    chk(hits, HIT_ZERO);
    pulse(1'b0, IDLE_T);
  endtask

  // two hits, then a miss on the third pulse
  task automatic sc_two_miss();
    pulse(1'b1, IDLE_T);
    pulse(1'b1, CONF_T);
    chk(hits, 2'h2);
    pulse(1'b0, CONF_T);
    chk(hits, HIT_ZERO);
    chk(alarm_led, 1'b0);
    pulse(1'b0, IDLE_T);
  endtask

  // three hits latch the alarm; a later miss leaves it latched
  task automatic sc_alarm();
    pulse(1'b1, IDLE_T);
    pulse(1'b1, CONF_T);
    chk(alarm_led, 1'b0);
    pulse(1'b1, CONF_T);
    chk(hits, HIT_ALARM);
    chk(alarm_led, 1'b1);
    chk(remote_en, 1'b1);
    pulse(1'b0, CONF_T);
    chk(alarm_led, 1'b1);
    chk(hits, HIT_ALARM);
    pulse(1'b1, IDLE_T);
    chk(remote_en, 1'b1);
  endtask

  // reset clears the latched alarm and the counter
  task automatic sc_reset();
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    #1;
    chk({emit, res_valid, res_above, hits, alarm_led, remote_en}, 32'h0);
    @(posedge sys_clk_i);
    rst_i <= 1'b0;
    pulse(1'b0, 0);
    chk(alarm_led, 1'b0);
    chk(hits, HIT_ZERO);
  endtask

  task automatic final_report();
    $display("mismatches=%0d compared=%0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // watchdog: the full run needs about 72000 cycles
  initial begin
    #(90_000 * 50);
    n_mismatch++;
    final_report();
  end

  // main sequence
  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    sc_idle();
    sc_hit_miss();
    sc_two_miss();
    sc_alarm();
    sc_reset();
    final_report();
  end
endmodule
`default_nettype wire
